// ---- core/csm_regs.sv ----
/*
 * Register block of the clock and supply-monitor unit: clock out, slow
 * mode, RC trim, reset-source flags, supply warning and its interrupt,
 * RC prescaler, oscillator select with handover flags.
 * Assumes a classic Wishbone master, one system clock, synchronous reset,
 * and a reset-cause input pair that is stable while rst_i is high.
 */
// How it works
// - Warning interrupt asserted only with enable set and CPU mask released.
// - Bit 1 of main clock register drives clock out; reset clears.
// - Bit 0 of main clock register selects CPU clock divided by 32.
// - Ten-bit trim: upper byte in trim register, low two in status.
// - Watchdog flag set by watchdog reset; cleared by zero write or by any other reset (LV or pin).
// - LV flag wins; watchdog flag alone means watchdog; neither means pin.
// - LV flag set by LV reset, cleared on read, kept over other resets.
// - LV flag reads zero when detector disabled; nothing depends on it.
// - Warning flag is read-only and follows the comparator.
// - Interrupt enable is RW; pending clears on entry to service routine.
// - Prescaler codes 1..4 divide by 2..16, others pass undivided.
// - Threshold field: low, medium, high, or detector off.
// - Wake-up ready flag set once clock active and settled.
// - RC ready flag set once clock active and settled.
// - Oscillator select: 0 RC, 1 wake-up oscillator, resets to 1.
// - Interrupt raised on threshold crossing in both directions.
// - Halt freezes supply register and blocks wake; Wait wakes.
module csm_regs #(
  parameter int SETTLE = csm_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Reset cause and detector configuration
  input  wire logic        wdg_reset_cause_i,
  input  wire logic        lv_reset_cause_i,
  input  wire logic        lv_detector_en_i,
  // Supply comparator and CPU state
  input  wire logic        supply_below_i,
  input  wire logic        irq_mask_released_i,
  input  wire logic        irq_service_entry_i,
  input  wire logic        halt_mode_i,
  // Clock control outputs
  output logic             clock_out_enable_o,
  output logic             cpu_clk_slow_o,
  output logic [4:0]       slow_div_count_o,
  output logic [9:0]       rc_trim_o,
  output logic [2:0]       rc_prescaler_select_o,
  output logic [4:0]       rc_divisor_log2_o,
  output logic [1:0]       supply_warning_threshold_o,
  output logic             supply_warning_detector_on_o,
  output logic             osc_source_select_o,
  // Interrupt to controller
  output logic             supply_warning_irq_o,
  output logic             wake_request_o
);

  // Settle counter is eight bits wide and must finish at least once
  if (SETTLE < 1 || SETTLE > 255) begin : g_bad_settle
    $error("SETTLE out of range");
  end

  // ********************************
  // Register state
  // ********************************
  logic        clock_out_enable_q;
  logic        slow_mode_select_q;
  logic [7:0]  trim_upper_q;
  logic [1:0]  trim_lower_q;
  logic        watchdog_reset_flag_q;
  logic        low_voltage_reset_flag_q;
  logic        supply_warning_irq_enable_q;
  logic [2:0]  rc_prescaler_select_q;
  logic [1:0]  supply_warning_threshold_q;
  logic        osc_source_select_q;
  logic        wakeup_osc_ready_flag_q;
  logic        rc_osc_ready_flag_q;
  logic [7:0]  settle_q;
  logic        sync1_q;
  logic        sync2_q;
  logic        warn_q;
  logic        warn_pend_q;
  logic [4:0]  slow_cnt_q;
  logic        ack_q;
  logic [31:0] dat_q;

  logic wr;
  logic rd;
  logic wr0;
  // Writes land on the edge that sees ack high, so a master that
  // aborts a write before the answer leaves every register untouched
  assign wr  = cyc_i && stb_i && we_i && ack_q;
  assign rd  = cyc_i && stb_i && !we_i && !ack_q;
  assign wr0 = wr && sel_i[0];

  // ********************************
  // Bus handshake and read mux
  // ********************************
  // One wait state; unmapped reads return zero, writes there are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= cyc_i && stb_i && !ack_q;
    end
  end
  assign ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0;
    end else if (rd) begin
      if (adr_i == csm_pkg::MAIN_CLOCK_CTRL_ADR)
        dat_q <= {30'h0, clock_out_enable_q, slow_mode_select_q};
      else if (adr_i == csm_pkg::RC_TRIM_HIGH_ADR)
        dat_q <= {24'h0, trim_upper_q};
      else if (adr_i == csm_pkg::SUPPLY_STATUS_ADR)
        dat_q <= {24'h0, 1'b0, trim_lower_q, watchdog_reset_flag_q, 1'b0,
                  low_voltage_reset_flag_q & lv_detector_en_i,
                  warn_q, supply_warning_irq_enable_q};
      else if (adr_i == csm_pkg::THRESH_PRESCALE_ADR)
        dat_q <= {24'h0, rc_prescaler_select_q, 3'h0,
                  supply_warning_threshold_q};
      else if (adr_i == csm_pkg::OSC_SELECT_ADR)
        dat_q <= {24'h0, 4'h0, wakeup_osc_ready_flag_q, rc_osc_ready_flag_q,
                  1'b0, osc_source_select_q};
      else if (adr_i == csm_pkg::SUPPLY_EVENT_ADR)
        dat_q <= {31'h0, warn_pend_q};
      else
        dat_q <= 32'h0;
    end
  end
  assign dat_o = dat_q;

  // ********************************
  // Main clock, trim, prescaler, threshold
  // ********************************
  // Halt freezes the supply register only
  logic sup_wr;
  assign sup_wr = wr0 && adr_i == csm_pkg::SUPPLY_STATUS_ADR && !halt_mode_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_out_enable_q <= 1'b0;
      slow_mode_select_q <= 1'b0;
    end else if (wr0 && adr_i == csm_pkg::MAIN_CLOCK_CTRL_ADR) begin
      clock_out_enable_q <= dat_i[csm_pkg::CLOCK_OUT_EN_BIT];
      slow_mode_select_q <= dat_i[csm_pkg::SLOW_MODE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_upper_q <= csm_pkg::TRIM_UPPER_RST;
      trim_lower_q <= csm_pkg::TRIM_LOWER_RST;
    end else begin
      if (wr0 && adr_i == csm_pkg::RC_TRIM_HIGH_ADR)
        trim_upper_q <= dat_i[7:0];
      if (sup_wr)
        trim_lower_q <= dat_i[csm_pkg::TRIM_LOWER_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_prescaler_select_q      <= 3'h0;
      supply_warning_threshold_q <= 2'h0;
    end else if (wr0 && adr_i == csm_pkg::THRESH_PRESCALE_ADR) begin
      rc_prescaler_select_q      <= dat_i[csm_pkg::PRESCALE_LSB +: 3];
      supply_warning_threshold_q <= dat_i[1:0];
    end
  end

  // ********************************
  // Reset-source flags
  // ********************************
  // Flags live through rst_i: the cause inputs are sampled while it is high
  logic lv_rd;
  assign lv_rd = rd && adr_i == csm_pkg::SUPPLY_STATUS_ADR && !halt_mode_i;

  always_ff @(posedge clk_i) begin
    if (rst_i && lv_reset_cause_i)
      watchdog_reset_flag_q <= 1'b0;
    else if (rst_i && wdg_reset_cause_i)
      watchdog_reset_flag_q <= 1'b1;
    else if (rst_i)
      watchdog_reset_flag_q <= watchdog_reset_flag_q & 1'b0;
    else if (sup_wr && !dat_i[csm_pkg::WDG_FLAG_BIT])
      watchdog_reset_flag_q <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i && lv_reset_cause_i)
      low_voltage_reset_flag_q <= 1'b1;
    else if (lv_rd)
      low_voltage_reset_flag_q <= 1'b0;
  end

  // ********************************
  // Supply warning and interrupt
  // ********************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= supply_below_i;
      sync2_q <= sync1_q;
    end
  end

  // Threshold code 3 switches the detector off entirely
  logic detector_on;
  logic crossing;
  assign detector_on = supply_warning_threshold_q != csm_pkg::THRESH_OFF;
  assign crossing    = detector_on && !halt_mode_i && (sync2_q != warn_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_q <= 1'b0;
    end else if (!halt_mode_i) begin
      warn_q <= detector_on && sync2_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_warning_irq_enable_q <= 1'b0;
    end else if (sup_wr) begin
      supply_warning_irq_enable_q <= dat_i[0];
    end
  end

  // A new crossing wins over the service-entry clear, so an edge
  // arriving during entry is not lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_pend_q <= 1'b0;
    end else if (crossing) begin
      warn_pend_q <= 1'b1;
    end else if (irq_service_entry_i) begin
      warn_pend_q <= 1'b0;
    end
  end

  assign supply_warning_irq_o = warn_pend_q && supply_warning_irq_enable_q &&
                                irq_mask_released_i;
  assign wake_request_o = supply_warning_irq_o && !halt_mode_i;

  // ********************************
  // Oscillator select and handover
  // ********************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_source_select_q <= 1'b1;
    end else if (wr0 && adr_i == csm_pkg::OSC_SELECT_ADR) begin
      osc_source_select_q <= dat_i[csm_pkg::OSC_SOURCE_BIT];
    end
  end

  // Settling modelled as a fixed count after each source switch
  logic [7:0] settle_max;
  assign settle_max = 8'(SETTLE);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_q                <= settle_max;
      wakeup_osc_ready_flag_q <= 1'b1;
      rc_osc_ready_flag_q     <= 1'b0;
    end else if (wr0 && adr_i == csm_pkg::OSC_SELECT_ADR &&
                 dat_i[0] != osc_source_select_q) begin
      settle_q                <= 8'h0;
      wakeup_osc_ready_flag_q <= 1'b0;
      rc_osc_ready_flag_q     <= 1'b0;
    end else if (settle_q != settle_max) begin
      settle_q <= settle_q + 8'h1;
      if (settle_q == settle_max - 8'h1) begin
        wakeup_osc_ready_flag_q <= osc_source_select_q;
        rc_osc_ready_flag_q     <= !osc_source_select_q;
      end
    end
  end

  // ********************************
  // Clock outputs
  // ********************************
  // Free-running so the divided clock needs no restart on mode change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_cnt_q <= 5'h0;
    end else begin
      slow_cnt_q <= slow_cnt_q + 5'h1;
    end
  end

  always_comb begin
    case (rc_prescaler_select_q)
      3'h1:    rc_divisor_log2_o = 5'h1;
      3'h2:    rc_divisor_log2_o = 5'h2;
      3'h3:    rc_divisor_log2_o = 5'h3;
      3'h4:    rc_divisor_log2_o = 5'h4;
      default: rc_divisor_log2_o = 5'h0;
    endcase
  end

  assign clock_out_enable_o          = clock_out_enable_q;
  assign cpu_clk_slow_o              = slow_mode_select_q;
  assign slow_div_count_o            = slow_cnt_q;
  assign rc_trim_o                   = {trim_upper_q, trim_lower_q};
  assign rc_prescaler_select_o       = rc_prescaler_select_q;
  assign supply_warning_threshold_o  = supply_warning_threshold_q;
  assign supply_warning_detector_on_o = detector_on;
  assign osc_source_select_o         = osc_source_select_q;

endmodule // csm_regs

// ---- core/csm_pkg.sv ----
/*
 * Constants for the clock and supply-monitor register block.
 * Assumes a classic Wishbone slave with 32-bit data, one word per register.
 */
package csm_pkg;

  // ********************************
  // Register indices and addresses
  // ********************************
  localparam logic [7:0] MAIN_CLOCK_CTRL_IDX  = 8'h3a;
  localparam logic [7:0] RC_TRIM_HIGH_IDX     = 8'h3b;
  localparam logic [7:0] SUPPLY_STATUS_IDX    = 8'h3c;
  localparam logic [7:0] THRESH_PRESCALE_IDX  = 8'h3d;
  localparam logic [7:0] OSC_SELECT_IDX       = 8'h51;
  localparam logic [7:0] SUPPLY_EVENT_IDX     = 8'h60;
  localparam int         ADDR_W               = 10;
  localparam logic [9:0] MAIN_CLOCK_CTRL_ADR  = 10'h0e8;
  localparam logic [9:0] RC_TRIM_HIGH_ADR     = 10'h0ec;
  localparam logic [9:0] SUPPLY_STATUS_ADR    = 10'h0f0;
  localparam logic [9:0] THRESH_PRESCALE_ADR  = 10'h0f4;
  localparam logic [9:0] OSC_SELECT_ADR       = 10'h144;
  localparam logic [9:0] SUPPLY_EVENT_ADR     = 10'h180;

  // ********************************
  // Field positions
  // ********************************
  localparam int CLOCK_OUT_EN_BIT   = 1;
  localparam int SLOW_MODE_BIT      = 0;
  localparam int TRIM_LOWER_LSB     = 5;
  localparam int WDG_FLAG_BIT       = 4;
  localparam int LV_FLAG_BIT        = 2;
  localparam int WARN_FLAG_BIT      = 1;
  localparam int WARN_IRQ_EN_BIT    = 0;
  localparam int PRESCALE_LSB       = 5;
  localparam int WAKE_READY_BIT     = 3;
  localparam int RC_READY_BIT       = 2;
  localparam int OSC_SOURCE_BIT     = 0;

  // ********************************
  // Reset values and codes
  // ********************************
  localparam logic [7:0] TRIM_UPPER_RST  = 8'hff;
  localparam logic [1:0] TRIM_LOWER_RST  = 2'h3;
  localparam logic [1:0] THRESH_OFF      = 2'h3;
  localparam logic [4:0] SLOW_DIV_MAX    = 5'h1f;
  localparam int         SETTLE_CYCLES   = 16;

  typedef enum logic [2:0] {
    CSM_DIV1, CSM_DIV2, CSM_DIV4, CSM_DIV8, CSM_DIV16
  } csm_prescale_t;

endpackage // csm_pkg

// ---- verification/csm_regs_properties.sv ----
/* Port checker for csm_regs, bound into every instance.
   Assumes one clock and a synchronous active-high reset. */
module csm_regs_checker (
  // Clock, reset, bus
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // Watched ports
  input wire logic       supply_below_i,
  input wire logic       irq_mask_released_i,
  input wire logic       halt_mode_i,
  input wire logic [4:0] slow_div_count_o,
  input wire logic [9:0] rc_trim_o,
  input wire logic [2:0] rc_prescaler_select_o,
  input wire logic [4:0] rc_divisor_log2_o,
  input wire logic [1:0] supply_warning_threshold_o,
  input wire logic       supply_warning_detector_on_o,
  input wire logic       osc_source_select_o,
  input wire logic       supply_warning_irq_o,
  input wire logic       wake_request_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ******************
  // Properties
  // ******************
  bus_ack_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bad ack");
  irq_mask_a: assert property (
    supply_warning_irq_o |-> irq_mask_released_i) else $error("irq masked");
  halt_wake_a: assert property (
    wake_request_o == (supply_warning_irq_o && !halt_mode_i))
    else $error("wake wrong");
  det_off_a: assert property (
    supply_warning_detector_on_o == (supply_warning_threshold_o != 2'h3))
    else $error("detector wrong");
  div_map_a: assert property (
    rc_divisor_log2_o == ((rc_prescaler_select_o inside {[1:4]}) ?
    {2'h0, rc_prescaler_select_o} : 5'h00)) else $error("divisor wrong");
  slow_count_a: assert property (
    1'b1 |=> slow_div_count_o == $past(slow_div_count_o) + 5'h01)
    else $error("slow count");
  reset_vals_a: assert property (
    $fell(rst_i) |-> rc_trim_o == 10'h3ff && osc_source_select_o)
    else $error("reset values");
  // Two sync stages: no comparator change reaches the irq in one edge
  sync_lag_a: assert property (
    $changed(supply_below_i) && !supply_warning_irq_o ##1
    $stable(irq_mask_released_i) |-> !supply_warning_irq_o)
    else $error("no sync lag");
  cover property (supply_warning_irq_o);
  cover property ($rose(wake_request_o));
  cover property (ack_o);
endmodule // csm_regs_checker

bind csm_regs csm_regs_checker i_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .supply_below_i, .irq_mask_released_i, .halt_mode_i,
  .slow_div_count_o, .rc_trim_o, .rc_prescaler_select_o, .rc_divisor_log2_o,
  .supply_warning_threshold_o, .supply_warning_detector_on_o,
  .osc_source_select_o, .supply_warning_irq_o, .wake_request_o);

// ---- verification/tb_top.sv ----
/* Self-checking bench for csm_regs over classic Wishbone.
   Assumes a 20 MHz clock; settle time shortened to 8 cycles. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ******************
  // Signals
  // ******************
  localparam logic [9:0] MC = csm_pkg::MAIN_CLOCK_CTRL_ADR;
  localparam logic [9:0] TR = csm_pkg::RC_TRIM_HIGH_ADR;
  localparam logic [9:0] SS = csm_pkg::SUPPLY_STATUS_ADR;
  localparam logic [9:0] TP = csm_pkg::THRESH_PRESCALE_ADR;
  localparam logic [9:0] OS = csm_pkg::OSC_SELECT_ADR;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, rdata;
  logic ack_o, wdg_reset_cause_i = 0, lv_reset_cause_i = 0;
  logic lv_detector_en_i = 1, supply_below_i = 0, irq_mask_released_i = 0;
  logic irq_service_entry_i = 0, halt_mode_i = 0;
  logic clock_out_enable_o, cpu_clk_slow_o, supply_warning_detector_on_o;
  logic osc_source_select_o, supply_warning_irq_o, wake_request_o;
  logic [4:0] slow_div_count_o, rc_divisor_log2_o;
  logic [9:0] rc_trim_o;
  logic [2:0] rc_prescaler_select_o;
  logic [1:0] supply_warning_threshold_o;
  int bad_count = 0;
  int samples_checked = 0;

  csm_regs #(.SETTLE(8)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .wdg_reset_cause_i,
    .lv_reset_cause_i, .lv_detector_en_i, .supply_below_i,
    .irq_mask_released_i, .irq_service_entry_i, .halt_mode_i,
    .clock_out_enable_o, .cpu_clk_slow_o, .slow_div_count_o, .rc_trim_o,
    .rc_prescaler_select_o, .rc_divisor_log2_o, .supply_warning_threshold_o,
    .supply_warning_detector_on_o, .osc_source_select_o,
    .supply_warning_irq_o, .wake_request_o);

  initial forever #25 clk_i = ~clk_i;
  // ******************
  // Tasks
  // ******************
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // Master waits for ack; only the bound n ends a hang
  task automatic wb(logic w, logic [9:0] a, logic [7:0] d);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) bad_count++;
    rdata = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] e, string n);
    wb(1'b0, a, 8'h00);
    chk(n, {24'h0, e}, rdata);
  endtask
  task automatic do_rst(logic w, logic l);
    wdg_reset_cause_i <= w;
    lv_reset_cause_i <= l;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wdg_reset_cause_i <= 1'b0;
    lv_reset_cause_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #250000;
    bad_count++;
    summarize();
  end
  // ******************
  // Tests
  // ******************
  initial begin
    do_rst(1'b0, 1'b1);
    rd(SS, 8'h64, "lv set");
    rd(SS, 8'h60, "lv read clr");
    do_rst(1'b1, 1'b0);
    rd(SS, 8'h70, "wdg");
    do_rst(1'b0, 1'b1);
    rd(SS, 8'h64, "lv wins");
    do_rst(1'b0, 1'b1);
    do_rst(1'b1, 1'b0);
    rd(SS, 8'h74, "lv kept");
    wb(1'b1, SS, 8'h60);
    rd(SS, 8'h60, "wdg clr");
    do_rst(1'b0, 1'b0);
    rd(SS, 8'h60, "pin");
    rd(MC, 8'h00, "main rst");
    rd(TR, 8'hff, "trim rst");
    rd(TP, 8'h00, "thr rst");
    rd(OS, 8'h09, "osc rst");
    wb(1'b1, 10'h100, 8'hff);
    rd(10'h100, 8'h00, "unmapped");
    wb(1'b1, MC, 8'h03);
    rd(MC, 8'h03, "main");
    chk("mco sms", 32'h3, {30'h0, clock_out_enable_o, cpu_clk_slow_o});
    wb(1'b1, TR, 8'h80);
    wb(1'b1, SS, 8'h20);
    chk("trim", 32'h201, {22'h0, rc_trim_o});
    for (int i = 0; i < 8; i++) begin
      wb(1'b1, TP, {i[2:0], 5'h00});
      chk("div", (i >= 1 && i <= 4) ? i : 0, {27'h0, rc_divisor_log2_o});
    end
    wb(1'b1, TP, 8'h20);
    chk("div2", 32'h1, {27'h0, rc_divisor_log2_o});
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, TP, {6'h00, i[1:0]});
      chk("det", {31'h0, i != 3}, {31'h0, supply_warning_detector_on_o});
    end
    supply_below_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(SS, 8'h20, "det off");
    wb(1'b1, TP, 8'h00);
    repeat (6) @(posedge clk_i);
    rd(SS, 8'h22, "flag hi");
    chk("irq dis", 0, {31'h0, supply_warning_irq_o});
    wb(1'b1, SS, 8'h21);
    chk("masked", 0, {31'h0, supply_warning_irq_o});
    irq_mask_released_i <= 1'b1;
    @(posedge clk_i);
    chk("irq fall", 1, {31'h0, supply_warning_irq_o});
    rd(csm_pkg::SUPPLY_EVENT_ADR, 8'h01, "event");
    halt_mode_i <= 1'b1;
    @(posedge clk_i);
    chk("halt", 0, {31'h0, wake_request_o});
    wb(1'b1, SS, 8'h00);
    rd(SS, 8'h23, "frozen");
    halt_mode_i <= 1'b0;
    @(posedge clk_i);
    chk("wake", 1, {31'h0, wake_request_o});
    irq_service_entry_i <= 1'b1;
    @(posedge clk_i);
    irq_service_entry_i <= 1'b0;
    @(posedge clk_i);
    chk("svc", 0, {31'h0, supply_warning_irq_o});
    supply_below_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("irq rise", 1, {31'h0, supply_warning_irq_o});
    rd(SS, 8'h21, "flag lo");
    wb(1'b1, OS, 8'h00);
    rd(OS, 8'h00, "settling");
    repeat (12) @(posedge clk_i);
    rd(OS, 8'h04, "rc rdy");
    chk("src", 0, {31'h0, osc_source_select_o});
    wb(1'b1, OS, 8'h01);
    repeat (12) @(posedge clk_i);
    rd(OS, 8'h09, "wk rdy");
    summarize();
  end
endmodule // tb_top
